//--- rtl/standby_mode_controller.sv
`timescale 1ns/100ps
`default_nettype none

module standby_mode_controller
  import standby_pkg::*;
#(
  parameter int SETTLE_CYC0 = 2 ** SETTLE_EXP0,
  parameter int SETTLE_CYC1 = 2 ** SETTLE_EXP1,
  parameter int SETTLE_CYC2 = 2 ** SETTLE_EXP2,
  parameter int SETTLE_CYC3 = 2 ** SETTLE_EXP3
) (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        clk_en_i,
  input  wire logic        halt_exec_i,
  input  wire logic        stop_exec_i,
  input  wire logic        irq_unmasked_i,
  input  wire logic        global_irq_accept_i,
  input  wire logic        osc_src_xtal_i,
  input  wire logic        osc_running_i,
  input  wire logic        opt_settle_sel_i,
  input  wire logic        opt_settle_sel_hi_i,
  input  wire logic        ls_osc_stoppable_i,
  input  wire logic        low_speed_osc_stop_bit_i,
  input  wire logic        wdt_clk_low_speed_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             cpu_clk_en_o,
  output logic             sys_osc_en_o,
  output logic             periph_clk_en_o,
  output logic             low_speed_osc_en_o,
  output logic             wdt_halt_o,
  output logic             state_hold_o,
  output logic             halt_mode_o,
  output logic             stop_mode_o,
  output logic             vector_irq_o
);

  // ****************************************
  // Declarations
  // ****************************************
  standby_state_e   state_reg;
  standby_state_e   state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [1:0]       settle_sel_reg;
  logic [1:0]       opt_sel_reg;
  logic             irq_accept_reg;
  logic             restart_done;
  logic             settle_done;
  logic             rst_done;
  logic             wake_done;
  logic             standby_next;
  logic             ls_req;
  logic [7:0]       reg_rdata_reg;
  logic             cpu_clk_en_reg;
  logic             sys_osc_en_reg;
  logic             periph_clk_en_reg;
  logic             ls_en_reg;
  logic             wdt_halt_reg;
  logic             hold_reg;
  logic             halt_mode_reg;
  logic             stop_mode_reg;
  logic             vector_reg;
  logic             in_settle;

  function automatic logic [CNT_W-1:0] settle_last(input logic [1:0] sel);
    int n;
    unique case (sel)
      2'h0: n = SETTLE_CYC0;
      2'h1: n = SETTLE_CYC1;
      2'h2: n = SETTLE_CYC2;
      2'h3: n = SETTLE_CYC3;
    endcase
    settle_last = CNT_W'(n - 1);
  endfunction

  // ****************************************
  // Select register
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      settle_sel_reg <= SETTLE_SEL_RST;
    end else if (clk_en_i && reg_wr_i && reg_addr_i == OSC_SETTLE_SEL_ADDR) begin
      settle_sel_reg <= reg_wdata_i[1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      reg_rdata_reg <= 8'h00;
    end else if (clk_en_i) begin
      if (reg_rd_i && reg_addr_i == OSC_SETTLE_SEL_ADDR) begin
        reg_rdata_reg <= {6'h00, settle_sel_reg};
      end else begin
        reg_rdata_reg <= 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      opt_sel_reg <= {opt_settle_sel_hi_i, opt_settle_sel_i};
    end
  end

  // ****************************************
  // Mode sequencer
  // ****************************************
  // Stop interval before restart
  assign restart_done = (cnt_reg >= CNT_W'(STOP_MIN_CYC - 1)) && osc_running_i;
  assign settle_done  = cnt_reg == settle_last(settle_sel_reg);
  assign rst_done     = osc_running_i &&
                        (!osc_src_xtal_i || cnt_reg == settle_last(opt_sel_reg));
  assign wake_done    = cnt_reg == (irq_accept_reg ? CNT_W'(WAKE_VEC_CYC - 1)
                                                   : CNT_W'(WAKE_NEXT_CYC - 1));
  assign in_settle    = state_reg == ST_SETTLE;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RST_SETTLE: begin
        if (rst_done) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stop_exec_i) begin
          state_next = irq_unmasked_i ? ST_WAKE : ST_STOP;
        end else if (halt_exec_i) begin
          state_next = irq_unmasked_i ? ST_WAKE : ST_HALT;
        end
      end
      ST_HALT: begin
        if (irq_unmasked_i) begin
          state_next = ST_WAKE;
        end
      end
      ST_STOP: begin
        if (irq_unmasked_i) begin
          state_next = ST_RESTART;
        end
      end
      ST_RESTART: begin
        if (restart_done) begin
          state_next = osc_src_xtal_i ? ST_SETTLE : ST_WAKE;
        end
      end
      ST_SETTLE: begin
        if (settle_done) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wake_done) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RST_SETTLE;
      end
    endcase
  end

  always_comb begin
    if (state_next != state_reg) begin
      cnt_next = '0;
    end else if ((state_reg == ST_SETTLE || state_reg == ST_RST_SETTLE) && !osc_running_i) begin
      cnt_next = '0;
    end else if (&cnt_reg) begin
      cnt_next = cnt_reg;
    end else begin
      cnt_next = cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= ST_RST_SETTLE;
    end else if (clk_en_i) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_reg <= '0;
    end else if (clk_en_i) begin
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_accept_reg <= 1'b0;
    end else if (clk_en_i && state_next == ST_WAKE && state_reg != ST_WAKE) begin
      irq_accept_reg <= global_irq_accept_i;
    end
  end

  // ****************************************
  // Clock and hold controls
  // ****************************************
  assign standby_next = state_next inside {ST_HALT, ST_STOP, ST_RESTART};
  // Stop bit honoured only when stoppable
  assign ls_req       = !(ls_osc_stoppable_i && low_speed_osc_stop_bit_i);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cpu_clk_en_reg    <= 1'b0;
      sys_osc_en_reg    <= 1'b1;
      periph_clk_en_reg <= 1'b0;
      hold_reg          <= 1'b0;
      halt_mode_reg     <= 1'b0;
      stop_mode_reg     <= 1'b0;
      vector_reg        <= 1'b0;
    end else if (clk_en_i) begin
      cpu_clk_en_reg    <= state_next == ST_RUN;
      // Oscillator and peripherals off in stop
      sys_osc_en_reg    <= state_next != ST_STOP;
      periph_clk_en_reg <= state_next inside {ST_RUN, ST_HALT, ST_WAKE};
      hold_reg          <= state_next inside {ST_HALT, ST_STOP, ST_RESTART, ST_SETTLE, ST_WAKE};
      halt_mode_reg     <= state_next == ST_HALT;
      stop_mode_reg     <= state_next == ST_STOP;
      vector_reg        <= state_reg == ST_WAKE && wake_done && irq_accept_reg;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ls_en_reg <= 1'b0;
    end else if (clk_en_i) begin
      ls_en_reg <= standby_next ? (ls_en_reg || ls_req) : ls_req;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wdt_halt_reg <= 1'b0;
    end else if (clk_en_i) begin
      wdt_halt_reg <= state_next == ST_STOP && ls_osc_stoppable_i && wdt_clk_low_speed_i;
    end
  end

  assign reg_rdata_o        = reg_rdata_reg;
  assign cpu_clk_en_o       = cpu_clk_en_reg;
  assign sys_osc_en_o       = sys_osc_en_reg;
  assign periph_clk_en_o    = periph_clk_en_reg;
  assign low_speed_osc_en_o = ls_en_reg;
  assign wdt_halt_o         = wdt_halt_reg;
  assign state_hold_o       = hold_reg;
  assign halt_mode_o        = halt_mode_reg;
  assign stop_mode_o        = stop_mode_reg;
  assign vector_irq_o       = vector_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i || !clk_en_i);

  sequence halt_entry_s;
    state_reg == ST_RUN && !stop_exec_i && halt_exec_i && !irq_unmasked_i;
  endsequence

  sequence halt_wake_vec_s;
    state_reg == ST_HALT && irq_unmasked_i && global_irq_accept_i;
  endsequence

  sequence halt_wake_next_s;
    state_reg == ST_HALT && irq_unmasked_i && !global_irq_accept_i;
  endsequence

  a_halt_gates_cpu: assert property (
    halt_entry_s |=> !cpu_clk_en_o && halt_mode_o && sys_osc_en_o)
    else $error("halt entry did not gate cpu clock");
  a_ls_keeps_running: assert property (
    state_reg inside {ST_HALT, ST_STOP} && !irq_unmasked_i && low_speed_osc_en_o
    |=> low_speed_osc_en_o)
    else $error("low speed oscillator stopped in standby");
  a_stop_osc_off: assert property (
    state_reg == ST_RUN && stop_exec_i && !irq_unmasked_i
    |=> !sys_osc_en_o && !periph_clk_en_o && stop_mode_o)
    else $error("stop entry left oscillator on");
  a_stop_irq_exit: assert property (
    state_reg == ST_STOP && irq_unmasked_i |=> sys_osc_en_o && !stop_mode_o)
    else $error("interrupt did not release stop");
  a_no_settle_int: assert property (
    state_reg == ST_RESTART && restart_done && !osc_src_xtal_i |=> state_reg == ST_WAKE)
    else $error("settling wait inserted for non crystal source");
  a_settle_length: assert property (
    $fell(in_settle) |-> $past(cnt_reg) == settle_last($past(settle_sel_reg)))
    else $error("settling wait length wrong");
  a_wake_vector: assert property (
    halt_wake_vec_s |-> ##[11:13] vector_irq_o)
    else $error("vectored service latency wrong");
  a_wake_next: assert property (
    halt_wake_next_s |-> ##[3:5] cpu_clk_en_o)
    else $error("resume latency wrong");
  a_halt_masked: assert property (
    state_reg == ST_HALT && !irq_unmasked_i |=> halt_mode_o && !cpu_clk_en_o)
    else $error("masked request left halt");
  a_standby_cancel: assert property (
    state_reg == ST_RUN && (halt_exec_i || stop_exec_i) && irq_unmasked_i
    |=> state_reg == ST_WAKE && !halt_mode_o && !stop_mode_o)
    else $error("pending request did not cancel standby");
  a_ls_not_stoppable: assert property (
    !ls_osc_stoppable_i |=> low_speed_osc_en_o)
    else $error("non stoppable oscillator stopped");

endmodule // standby_mode_controller

`default_nettype wire

//--- rtl/standby_pkg.sv
// Summary of operation
// - Halt instruction gates CPU clock only
// - Running low-speed oscillator stays on in HALT
// - Stop instruction stops system oscillator and peripherals
// - Unmasked interrupt releases STOP mode
// - Registers, flags and memory keep their values
// - Port latches and output buffers are held
// - Stop bit acts only if option allows
// - Non-stoppable low-speed oscillator always runs; code holds it off in reset and turns it on at first enabled clock after
// - Watchdog on low-speed clock halts in STOP if low-speed oscillator is stoppable
// - Running low-speed oscillator cannot stop in STOP
// - Settling wait only for crystal/ceramic source
// - No wait for internal or external clock
// - Codes select 2^10, 2^12, 2^15, 2^17 periods
// - Settling counted from oscillation start; after STOP code counts from end of stop interval if that is later
// - Stop interval of at least 17 us after release
// - Reset settling time comes from option setting
// - Unmasked request releases HALT with fixed latency
// - Pending unmasked request cancels standby at once
// - Reset releases HALT and restarts normally

package standby_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] OSC_SETTLE_SEL_ADDR = 16'hFFF4;
  localparam logic [1:0]  SETTLE_SEL_RST      = 2'h3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ       = 100;
  localparam int STOP_MIN_US   = 17;
  localparam int STOP_MIN_CYC  = STOP_MIN_US * CLK_MHZ;
  localparam int WAKE_VEC_CYC  = 11;
  localparam int WAKE_NEXT_CYC = 3;
  localparam int SETTLE_EXP0   = 10;
  localparam int SETTLE_EXP1   = 12;
  localparam int SETTLE_EXP2   = 15;
  localparam int SETTLE_EXP3   = 17;
  localparam int CNT_W         = 18;

  typedef enum logic [2:0] {
    ST_RST_SETTLE,
    ST_RUN,
    ST_HALT,
    ST_STOP,
    ST_RESTART,
    ST_SETTLE,
    ST_WAKE
  } standby_state_e;

endpackage

//--- sim/osc_model.sv
`timescale 1ns/100ps
`default_nettype none

module osc_model (
  input  wire logic        core_clk_i,
  input  wire logic        osc_en_i,
  input  wire logic [11:0] start_dly_i,
  output logic             osc_running_o
);
  logic [11:0] cnt_reg = 12'h000;

  always_ff @(posedge core_clk_i) begin
    if (!osc_en_i) begin
      cnt_reg       <= 12'h000;
      osc_running_o <= 1'b0;
    end else if (cnt_reg >= start_dly_i) begin
      osc_running_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 12'h001;
    end
  end
endmodule // osc_model

`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import standby_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic clk, srst, ce, halt, stop, irq, accept, xtal, opt_lo, opt_hi, stpbl, sbit, wdt_ls, wr, rd;
  logic osc_run, cpu, sys, per, lso, wdth, hold, hm, sm, vec;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, q;
  logic [11:0] dly;
  int bad_count, samples_checked, n, lo, seed;

  standby_mode_controller #(.SETTLE_CYC0(8), .SETTLE_CYC1(16), .SETTLE_CYC2(32),
    .SETTLE_CYC3(64)) u_standby_mode_controller (
    .core_clk_i(clk), .srst_i(srst), .clk_en_i(ce), .halt_exec_i(halt),
    .stop_exec_i(stop), .irq_unmasked_i(irq), .global_irq_accept_i(accept),
    .osc_src_xtal_i(xtal), .osc_running_i(osc_run), .opt_settle_sel_i(opt_lo),
    .opt_settle_sel_hi_i(opt_hi), .ls_osc_stoppable_i(stpbl),
    .low_speed_osc_stop_bit_i(sbit), .wdt_clk_low_speed_i(wdt_ls), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .cpu_clk_en_o(cpu), .sys_osc_en_o(sys), .periph_clk_en_o(per),
    .low_speed_osc_en_o(lso), .wdt_halt_o(wdth), .state_hold_o(hold),
    .halt_mode_o(hm), .stop_mode_o(sm), .vector_irq_o(vec));

  osc_model u_osc_model (.core_clk_i(clk), .osc_en_i(sys), .start_dly_i(dly),
    .osc_running_o(osc_run));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wait_cpu;
    n = 0;
    while (cpu !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 20000) begin
        bad_count++;
        test_done();
      end
    end
  endtask

  task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w);
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    cyc(1);
    q = rdata;
    wr = 1'b0;
    rd = 1'b0;
    cyc(1);
  endtask

  task automatic pulse(input logic s);
    halt = !s;
    stop = s;
    cyc(1);
    halt = 1'b0;
    stop = 1'b0;
    cyc(1);
  endtask

  task automatic do_reset;
    {opt_hi, opt_lo} = 2'($random(seed));
    srst = 1'b1;
    dly = 12'h000;
    cyc(8);
    srst = 1'b0;
    wait_cpu();
    chk(8'(n >= (8 << {opt_hi, opt_lo}) && n <= (8 << {opt_hi, opt_lo}) + 10), 8'h01, "boot");
    chk(8'({hm, sm}), 8'h00, "modes after reset");
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    seed = 32'h07177F29;
    {srst, halt, stop, irq, accept, stpbl, sbit, wdt_ls, wr, rd} = '0;
    {xtal, opt_lo, opt_hi, addr, wdata} = '0;
    ce = 1'b1;
    xtal = 1'b1;
    dly = 12'h000;
    do_reset();
    acc(16'hFFF4, 8'h00, 1'b0);
    chk(q, 8'h03, "select reset");
    for (int i = 0; i < 4; i++) begin
      acc(16'hFFF4, {6'($random(seed)), 2'(i)}, 1'b1);
      acc(16'hFFF5, 8'($random(seed)), 1'b1);
      acc(16'hFFF4, 8'h00, 1'b0);
      chk(q, 8'(i), "select readback");
      acc(16'hFFF5, 8'h00, 1'b0);
      chk(q, 8'h00, "unmapped read");
    end
    for (int i = 0; i < 4; i++) begin
      {stpbl, sbit} = 2'(i);
      cyc(2);
      chk(8'(lso), 8'(i != 3), "low-speed enable");
    end
    {stpbl, sbit} = 2'b00;
    $display("register and option test done");
    for (int i = 0; i < 2; i++) begin
      accept = i[0];
      pulse(1'b0);
      chk(8'({cpu, hm, sys, per, lso, hold}), 8'h1F, "halt state");
      ce = 1'b0;
      irq = 1'b1;
      cyc(4);
      chk(8'({hm, cpu, hold}), 8'h05, "frozen by clock enable");
      ce = 1'b1;
      irq = 1'b0;
      cyc(6);
      chk(8'(hm), 8'h01, "masked halt held");
      irq = 1'b1;
      n = 0;
      while ((accept ? vec : cpu) !== 1'b1 && n < 50) begin
        cyc(1);
        n++;
      end
      chk(8'(n >= (accept ? 11 : 3) && n <= (accept ? 13 : 5)), 8'h01, "halt wake latency");
      irq = 1'b0;
      wait_cpu();
    end
    irq = 1'b1;
    pulse(1'b0);
    chk(8'(hm), 8'h00, "pending request");
    irq = 1'b0;
    wait_cpu();
    pulse(1'b0);
    do_reset();
    $display("halt test done");
    accept = 1'b0;
    for (int i = 0; i < 5; i++) begin
      xtal = i < 4;
      acc(16'hFFF4, 8'(i % 4), 1'b1);
      dly = 12'($unsigned($random(seed)) % 2000);
      {stpbl, wdt_ls} = 2'($random(seed));
      pulse(1'b1);
      sbit = 1'b1;
      cyc(3);
      chk(8'({sys, per, sm, cpu, hold, lso}), 8'h0B, "stop state");
      chk(8'(wdth), 8'(stpbl & wdt_ls), "watchdog halt");
      irq = 1'b1;
      wait_cpu();
      irq = 1'b0;
      sbit = 1'b0;
      lo = (dly > STOP_MIN_CYC ? dly : STOP_MIN_CYC) + (xtal ? 8 << (i % 4) : 0);
      chk(8'(n >= lo && n <= lo + 12), 8'h01, "stop release time");
    end
    $display("stop test done");
    test_done();
  end
endmodule // tb_top

`default_nettype wire
